// ---- verif/host_port_model.sv ----
`timescale 1ns/10ps
// Host on the register port: one strobe per access, driven just after the edge
module host_port_model (
	input  wire logic       core_clk,
	output logic            reg_wr_en,
	output logic            reg_rd_en,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rd_valid
);
	localparam time SKEW = 2ns;

	// Idle port at time zero
	initial
	begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
	end

	// Idle lines flip afterwards so nothing leans on stale values
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge core_clk);
		#SKEW;
		reg_addr  = addr;
		reg_wdata = data;
		reg_wr_en = 1'b1;
		@(posedge core_clk);
		#SKEW;
		reg_wr_en = 1'b0;
		reg_addr  = ~addr;
		reg_wdata = ~data;
	endtask : write_reg

	// Answer awaited a few cycles only
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
		output logic ok);
		@(posedge core_clk);
		#SKEW;
		reg_addr  = addr;
		reg_rd_en = 1'b1;
		@(posedge core_clk);
		#SKEW;
		reg_rd_en = 1'b0;
		reg_addr  = ~addr;
		ok        = 1'b0;
		for (int i = 0; i < 4 && !ok; i++)
		begin
			if (reg_rd_valid === 1'b1)
			begin
				ok   = 1'b1;
				data = reg_rdata;
			end
			else
			begin
				@(posedge core_clk);
				#SKEW;
			end
		end
	endtask : read_reg

	// Drive setup: strength all ones, supply never the undefined code
	task automatic program_drive(input logic [7:0] base, input logic [1:0] phase,
		input logic [1:0] supply, input logic [2:0] standard);
		write_reg(base + 8'h3, {phase, 3'h0, 3'h7});
		write_reg(base + 8'h5, {3'h0, (supply == 2'h3) ? 2'h0 : supply, standard});
	endtask : program_drive
endmodule : host_port_model

// ---- verif/outcfg_assertions.sv ----
`timescale 1ns/10ps
// Shadows the page from the register port and holds the outputs to it
module outcfg_checker (
	input wire logic                  core_clk,
	input wire logic                  srst,
	input wire logic                  reg_wr_en,
	input wire logic                  reg_rd_en,
	input wire logic [7:0]            reg_addr,
	input wire logic [7:0]            reg_wdata,
	input wire logic [7:0]            reg_rdata,
	input wire logic                  reg_rd_valid,
	input wire logic                  out2_positive_pin_source,
	input wire logic                  out2_negative_pin_source,
	input wire logic                  out3_positive_pin_source,
	input wire logic                  out3_negative_pin_source,
	input wire outcfg_pkg::drv_ctrl_t out2_drv_ctrl,
	input wire outcfg_pkg::drv_ctrl_t out3_drv_ctrl
);
	logic [7:0] shadow_q [16];
	logic [7:0] exp_rd_q;
	logic [1:0] quiet_q;
	logic       mapped;

	// Offsets 0x20-25 and 0x28-2D only
	assign mapped = (reg_addr[7:4] == 4'h2) && (reg_addr[2:0] <= 3'h5);

	// Shadow page, written at the same edge as the design
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < 16; i++)
				shadow_q[i] <= 8'h00;
		end
		else if (reg_wr_en && mapped)
			shadow_q[reg_addr[3:0]] <= reg_wdata;
	end

	// Taken before a same-cycle write lands, so a read sees the old value
	always_ff @(posedge core_clk)
	begin
		if (srst)
			exp_rd_q <= 8'h00;
		else if (reg_rd_en)
			exp_rd_q <= mapped ? shadow_q[reg_addr[3:0]] : 8'h00;
	end

	// Decode lags a write by two edges; check only once it has settled
	always_ff @(posedge core_clk)
	begin
		if (srst || reg_wr_en)
			quiet_q <= 2'h0;
		else if (quiet_q != 2'h3)
			quiet_q <= quiet_q + 2'h1;
	end

	// Expected and seen decoded controls
	function automatic logic [13:0] expect_ctrl(input logic [7:0] ps, dly, sd);
		return {sd[2:0] == 3'h0 || sd[2:0] == 3'h4,
			sd[2:0] == 3'h4, sd[2:0] == 3'h2, sd[2:0] == 3'h3,
			sd[2:0] == 3'h1 || sd[2:0] == 3'h5, sd[2:0] == 3'h1, sd[4:3],
			sd[4:3] != 2'h3, ps[2:0], dly[7:6]};
	endfunction : expect_ctrl
	function automatic logic [13:0] seen_ctrl(input outcfg_pkg::drv_ctrl_t d);
		return {d.lvds_en, d.lvds_boost, d.cml_en, d.hcsl_en, d.lvpecl_en, d.cm_current_en,
			d.supply_select, d.supply_valid, d.drive_strength, d.fine_delay_steps};
	endfunction : seen_ctrl

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence answer_s;
		##1 reg_rd_valid;
	endsequence
	sequence settled_s;
		quiet_q == 2'h3;
	endsequence

	rd_answer_a:
		assert property (reg_rd_en |-> answer_s) else $error("read got no valid pulse");
	rd_quiet_a:
		assert property (!reg_rd_en |=> !reg_rd_valid) else $error("valid without a read");
	rd_data_a:
		assert property (reg_rd_valid |-> reg_rdata == exp_rd_q)
		else $error("read data differs from page");
	phase2_route_a:
		assert property (settled_s |-> (out2_positive_pin_source ^ out2_negative_pin_source)
			== (shadow_q[3][7] ~^ shadow_q[3][6])) else $error("out2 pin routing wrong");
	phase3_route_a:
		assert property (settled_s |-> (out3_positive_pin_source ^ out3_negative_pin_source)
			== (shadow_q[11][7] ~^ shadow_q[11][6])) else $error("out3 pin routing wrong");
	drv2_ctrl_a:
		assert property (settled_s |-> seen_ctrl(out2_drv_ctrl)
			== expect_ctrl(shadow_q[3], shadow_q[4], shadow_q[5]))
		else $error("out2 driver controls wrong");
	drv3_ctrl_a:
		assert property (settled_s |-> seen_ctrl(out3_drv_ctrl)
			== expect_ctrl(shadow_q[11], shadow_q[12], shadow_q[13]))
		else $error("out3 driver controls wrong");
endmodule : outcfg_checker

bind output_divider_config_regs outcfg_checker u_chk (.core_clk(core_clk), .srst(srst),
	.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
	.out2_positive_pin_source(out2_positive_pin_source),
	.out2_negative_pin_source(out2_negative_pin_source),
	.out3_positive_pin_source(out3_positive_pin_source),
	.out3_negative_pin_source(out3_negative_pin_source),
	.out2_drv_ctrl(out2_drv_ctrl), .out3_drv_ctrl(out3_drv_ctrl));

// ---- verif/tb_output_divider_config_regs.sv ----
`timescale 1ns/10ps
`define CHECK(got, exp) \
	begin \
		checks++; \
		if ((got) !== (exp)) \
		begin \
			errors++; \
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, (got), (exp)); \
		end \
	end

// Bench for the output two and three configuration page
module tb_output_divider_config_regs;
	logic                  core_clk;
	logic                  srst;
	logic                  reg_wr_en;
	logic                  reg_rd_en;
	logic [7:0]            reg_addr;
	logic [7:0]            reg_wdata;
	logic [7:0]            reg_rdata;
	logic                  reg_rd_valid;
	logic                  p2;
	logic                  n2;
	logic                  p3;
	logic                  n3;
	outcfg_pkg::drv_ctrl_t ctrl2;
	outcfg_pkg::drv_ctrl_t ctrl3;
	int                    errors;
	int                    checks;
	logic [7:0]            rd;
	logic                  ok;

	output_divider_config_regs dut (.core_clk(core_clk), .srst(srst), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
		.out2_positive_pin_source(p2), .out2_negative_pin_source(n2),
		.out3_positive_pin_source(p3), .out3_negative_pin_source(n3),
		.out2_drv_ctrl(ctrl2), .out3_drv_ctrl(ctrl3));
	host_port_model host (.core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid));

	// 10 MHz clock
	initial
		core_clk = 1'b0;
	always #50 core_clk = ~core_clk;

	// Verdict and end of run
	task automatic close_out;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out

	// Read one register and compare; a missing answer ends the run
	task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
		host.read_reg(addr, rd, ok);
		if (!ok)
		begin
			errors++;
			close_out();
		end
		`CHECK(rd, exp)
	endtask : rd_check

	// Cycles until a positive pin rises, bounded
	task automatic wait_rise(input logic sel3, output int n);
		logic last;
		last = sel3 ? p3 : p2;
		for (n = 1; n < 400; n++)
		begin
			@(posedge core_clk);
			#2;
			if ((sel3 ? p3 : p2) && !last)
				return;
			last = sel3 ? p3 : p2;
		end
		errors++;
		close_out();
	endtask : wait_rise

	// Divider and delay of one output; spare nibble bits always set
	task automatic set_timing(input logic [7:0] base, input logic [19:0] div,
		input logic [7:0] dly);
		host.write_reg(base, {4'hF, div[19:16]});
		host.write_reg(base + 8'h1, div[15:8]);
		host.write_reg(base + 8'h2, div[7:0]);
		host.write_reg(base + 8'h4, dly);
	endtask : set_timing

	// Zero after reset, pattern read back, unmapped offset reads zero
	task automatic test_storage;
		logic [7:0] a;
		for (int i = 0; i < 24; i++)
		begin
			a = 8'h20 + 8'(i % 12 / 6 * 8 + i % 6);
			if (i < 12)
				rd_check(a, 8'h00);
			host.write_reg(a, a ^ 8'hE4);
		end
		host.write_reg(8'h27, 8'hFF);
		for (int i = 0; i < 12; i++)
		begin
			a = 8'h20 + 8'(i / 6 * 8 + i % 6);
			rd_check(a, a ^ 8'hE4);
		end
		rd_check(8'h27, 8'h00);
		$display("test_storage done");
	endtask : test_storage

	// Every phase code on output two against output three as the true clock
	task automatic test_phase;
		host.program_drive(8'h28, 2'h0, 2'h1, 3'h0);
		set_timing(8'h20, 20'h00004, 8'h00);
		set_timing(8'h28, 20'h00004, 8'h00);
		for (int p = 0; p < 4; p++)
		begin
			host.program_drive(8'h20, 2'(p), 2'h2, 3'h3);
			repeat (4) @(posedge core_clk);
			for (int c = 0; c < 8; c++)
			begin
				@(posedge core_clk);
				#2;
				`CHECK({p2, n2}, {p3 ^ p[1], p3 ^ ~p[0]})
				`CHECK(n3, ~p3)
			end
		end
		$display("test_phase done");
	endtask : test_phase

	// Rise-to-rise period for low-byte and mid-byte divide values
	task automatic test_period;
		int n;
		for (int k = 0; k < 2; k++)
		begin
			set_timing(8'h28, k ? 20'h00106 : 20'h00005, 8'h00);
			wait_rise(1'b1, n);
			wait_rise(1'b1, n);
			`CHECK(n, k ? 262 : 5)
		end
		$display("test_period done");
	endtask : test_period

	// Coarse delay of output three relative to output two, fine steps alongside
	task automatic test_delay;
		int t2;
		int t3;
		host.program_drive(8'h20, 2'h0, 2'h0, 3'h0);
		for (int k = 0; k < 2; k++)
		begin
			set_timing(8'h20, 20'h00050, 8'hC0);
			set_timing(8'h28, 20'h00050, k ? 8'h3F : 8'h85);
			fork
				wait_rise(1'b0, t2);
				wait_rise(1'b1, t3);
			join
			`CHECK(t3 - t2, k ? 63 : 5)
			`CHECK({ctrl2.fine_delay_steps, ctrl3.fine_delay_steps}, {2'h3, k ? 2'h0 : 2'h2})
		end
		$display("test_delay done");
	endtask : test_delay

	// All eight standard codes, supplies cycling through the defined ones
	task automatic test_driver;
		logic [5:0] want [8] = '{6'h20, 6'h03, 6'h08, 6'h04, 6'h30, 6'h02, 6'h00, 6'h00};
		logic [5:0] got;
		logic [5:0] sup;
		for (int c = 0; c < 8; c++)
		begin
			host.program_drive(8'h28, 2'h0, 2'(c % 3), 3'(c));
			repeat (3) @(posedge core_clk);
			#2;
			got = {ctrl3.lvds_en, ctrl3.lvds_boost, ctrl3.cml_en, ctrl3.hcsl_en,
				ctrl3.lvpecl_en, ctrl3.cm_current_en};
			sup = {ctrl3.supply_select, ctrl3.supply_valid, ctrl3.drive_strength};
			`CHECK(got, want[c])
			`CHECK(sup, {2'(c % 3), 1'b1, 3'h7})
		end
		$display("test_driver done");
	endtask : test_driver

	// Reset for six cycles, then the scenarios in turn
	initial
	begin
		errors = 0;
		checks = 0;
		srst   = 1'b1;
		repeat (6) @(posedge core_clk);
		#2;
		srst = 1'b0;
		test_storage();
		test_phase();
		test_period();
		test_delay();
		test_driver();
		close_out();
	end
endmodule : tb_output_divider_config_regs

// ---- verilog/outcfg_pkg.sv ----
package outcfg_pkg;

	// Register page offsets, output two
	localparam logic [7:0] OUT2_DIV_HIGH_OFS   = 8'h20;
	localparam logic [7:0] OUT2_DIV_MID_OFS    = 8'h21;
	localparam logic [7:0] OUT2_DIV_LOW_OFS    = 8'h22;
	localparam logic [7:0] OUT2_PHASE_STR_OFS  = 8'h23;
	localparam logic [7:0] OUT2_DELAY_OFS      = 8'h24;
	localparam logic [7:0] OUT2_SUPPLY_DRV_OFS = 8'h25;

	// Register page offsets, output three
	localparam logic [7:0] OUT3_DIV_HIGH_OFS   = 8'h28;
	localparam logic [7:0] OUT3_DIV_MID_OFS    = 8'h29;
	localparam logic [7:0] OUT3_DIV_LOW_OFS    = 8'h2A;
	localparam logic [7:0] OUT3_PHASE_STR_OFS  = 8'h2B;
	localparam logic [7:0] OUT3_DELAY_OFS      = 8'h2C;
	localparam logic [7:0] OUT3_SUPPLY_DRV_OFS = 8'h2D;

	// Reset values
	localparam logic [7:0]  REG_RESET_VALUE = 8'h00;
	localparam logic [19:0] DIV_RESET_VALUE = 20'h00000;

	// Field positions
	localparam int DIV_HIGH_MSB    = 3;
	localparam int PHASE_SEL_LSB   = 6;
	localparam int STRENGTH_MSB    = 2;
	localparam int COARSE_DLY_MSB  = 5;
	localparam int FINE_DLY_LSB    = 6;
	localparam int SUPPLY_LSB      = 3;
	localparam int DRIVER_MSB      = 2;

	// Smallest divide value the counter can produce from whole cycles
	localparam logic [19:0] DIV_MIN_RUN = 20'h00002;

	// Fine delay step in picoseconds, for the analog delay line
	localparam int FINE_STEP_PS = 30;

	// Phase selection codes
	localparam logic [1:0] PHASE_TRUE_COMP = 2'h0;
	localparam logic [1:0] PHASE_TRUE_TRUE = 2'h1;
	localparam logic [1:0] PHASE_COMP_COMP = 2'h2;
	localparam logic [1:0] PHASE_COMP_TRUE = 2'h3;

	// Supply codes
	localparam logic [1:0] SUPPLY_UNDEFINED = 2'h3;

	// Driver standard codes
	localparam logic [2:0] DRV_LVDS         = 3'h0;
	localparam logic [2:0] DRV_LVPECL_CM    = 3'h1;
	localparam logic [2:0] DRV_CML          = 3'h2;
	localparam logic [2:0] DRV_HCSL         = 3'h3;
	localparam logic [2:0] DRV_LVDS_BOOST   = 3'h4;
	localparam logic [2:0] DRV_LVPECL_NO_CM = 3'h5;

	// Output stage sequencer states
	typedef enum logic [1:0] {
		ST_WAIT = 2'b01,
		ST_RUN  = 2'b10
	} stage_state_t;

	// Decoded analog driver controls of one output
	typedef struct packed {
		logic       lvds_en;
		logic       lvds_boost;
		logic       cml_en;
		logic       hcsl_en;
		logic       lvpecl_en;
		logic       cm_current_en;
		logic [1:0] supply_select;
		logic       supply_valid;
		logic [2:0] drive_strength;
		logic [1:0] fine_delay_steps;
	} drv_ctrl_t;

endpackage : outcfg_pkg

// ---- verilog/output_divider_config_regs.sv ----
`timescale 1ns/10ps
module output_divider_config_regs (
	input  wire logic              core_clk,
	input  wire logic              srst,
	input  wire logic              reg_wr_en,
	input  wire logic              reg_rd_en,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	output logic [7:0]             reg_rdata,
	output logic                   reg_rd_valid,
	output logic                   out2_positive_pin_source,
	output logic                   out2_negative_pin_source,
	output logic                   out3_positive_pin_source,
	output logic                   out3_negative_pin_source,
	output outcfg_pkg::drv_ctrl_t  out2_drv_ctrl,
	output outcfg_pkg::drv_ctrl_t  out3_drv_ctrl
);

	logic [7:0] out2_div_high_q;
	logic [7:0] out2_div_mid_q;
	logic [7:0] out2_div_low_q;
	logic [7:0] out2_phase_str_q;
	logic [7:0] out2_delay_q;
	logic [7:0] out2_supply_drv_q;
	logic [7:0] out3_div_high_q;
	logic [7:0] out3_div_mid_q;
	logic [7:0] out3_div_low_q;
	logic [7:0] out3_phase_str_q;
	logic [7:0] out3_delay_q;
	logic [7:0] out3_supply_drv_q;
	logic       restart_q;
	logic       restart_d;
	logic [19:0] out2_div_value;
	logic [19:0] out3_div_value;

	// Build the divide value; spare nibble bits never reach the divider
	function automatic logic [19:0] div_assemble(
		input logic [7:0] high_byte,
		input logic [7:0] mid_byte,
		input logic [7:0] low_byte
	);
		div_assemble = {high_byte[outcfg_pkg::DIV_HIGH_MSB:0], mid_byte, low_byte};
	endfunction : div_assemble

	// Decode one output's control bytes into driver controls
	function automatic outcfg_pkg::drv_ctrl_t drv_decode(
		input logic [7:0] phase_str,
		input logic [7:0] delay_code,
		input logic [7:0] supply_drv
	);
		outcfg_pkg::drv_ctrl_t c;
		logic [2:0]            std;
		c   = '0;
		std = supply_drv[outcfg_pkg::DRIVER_MSB:0];
		case (std)
			outcfg_pkg::DRV_LVDS:
				c.lvds_en = 1'b1;
			outcfg_pkg::DRV_LVDS_BOOST:
			begin
				c.lvds_en    = 1'b1;
				c.lvds_boost = 1'b1;
			end
			outcfg_pkg::DRV_CML:
				c.cml_en = 1'b1;
			outcfg_pkg::DRV_HCSL:
				c.hcsl_en = 1'b1;
			outcfg_pkg::DRV_LVPECL_CM:
			begin
				c.lvpecl_en     = 1'b1;
				c.cm_current_en = 1'b1;
			end
			outcfg_pkg::DRV_LVPECL_NO_CM:
				c.lvpecl_en = 1'b1;
			// Undescribed codes leave every driver off rather than guess
			default:
				c.lvds_en = 1'b0;
		endcase
		c.supply_select    = supply_drv[outcfg_pkg::SUPPLY_LSB +: 2];
		c.supply_valid     = (c.supply_select != outcfg_pkg::SUPPLY_UNDEFINED);
		c.drive_strength   = phase_str[outcfg_pkg::STRENGTH_MSB:0];
		c.fine_delay_steps = delay_code[outcfg_pkg::FINE_DLY_LSB +: 2];
		drv_decode = c;
	endfunction : drv_decode

	// Register writes; unmapped offsets are ignored
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			out2_div_high_q   <= outcfg_pkg::REG_RESET_VALUE;
			out2_div_mid_q    <= outcfg_pkg::REG_RESET_VALUE;
			out2_div_low_q    <= outcfg_pkg::REG_RESET_VALUE;
			out2_phase_str_q  <= outcfg_pkg::REG_RESET_VALUE;
			out2_delay_q      <= outcfg_pkg::REG_RESET_VALUE;
			out2_supply_drv_q <= outcfg_pkg::REG_RESET_VALUE;
			out3_div_high_q   <= outcfg_pkg::REG_RESET_VALUE;
			out3_div_mid_q    <= outcfg_pkg::REG_RESET_VALUE;
			out3_div_low_q    <= outcfg_pkg::REG_RESET_VALUE;
			out3_phase_str_q  <= outcfg_pkg::REG_RESET_VALUE;
			out3_delay_q      <= outcfg_pkg::REG_RESET_VALUE;
			out3_supply_drv_q <= outcfg_pkg::REG_RESET_VALUE;
		end
		else if (reg_wr_en)
		begin
			if (reg_addr == outcfg_pkg::OUT2_DIV_HIGH_OFS)
				out2_div_high_q <= reg_wdata;
			else if (reg_addr == outcfg_pkg::OUT2_DIV_MID_OFS)
				out2_div_mid_q <= reg_wdata;
			else if (reg_addr == outcfg_pkg::OUT2_DIV_LOW_OFS)
				out2_div_low_q <= reg_wdata;
			else if (reg_addr == outcfg_pkg::OUT2_PHASE_STR_OFS)
				out2_phase_str_q <= reg_wdata;
			else if (reg_addr == outcfg_pkg::OUT2_DELAY_OFS)
				out2_delay_q <= reg_wdata;
			else if (reg_addr == outcfg_pkg::OUT2_SUPPLY_DRV_OFS)
				out2_supply_drv_q <= reg_wdata;
			else if (reg_addr == outcfg_pkg::OUT3_DIV_HIGH_OFS)
				out3_div_high_q <= reg_wdata;
			else if (reg_addr == outcfg_pkg::OUT3_DIV_MID_OFS)
				out3_div_mid_q <= reg_wdata;
			else if (reg_addr == outcfg_pkg::OUT3_DIV_LOW_OFS)
				out3_div_low_q <= reg_wdata;
			else if (reg_addr == outcfg_pkg::OUT3_PHASE_STR_OFS)
				out3_phase_str_q <= reg_wdata;
			else if (reg_addr == outcfg_pkg::OUT3_DELAY_OFS)
				out3_delay_q <= reg_wdata;
			else if (reg_addr == outcfg_pkg::OUT3_SUPPLY_DRV_OFS)
				out3_supply_drv_q <= reg_wdata;
		end
	end

	// Any divider or delay write realigns both outputs together,
	// so the coarse delays stay relative to a common start
	always_comb
	begin
		restart_d = 1'b0;
		if (reg_wr_en)
		begin
			if (reg_addr == outcfg_pkg::OUT2_DIV_HIGH_OFS)
				restart_d = 1'b1;
			else if (reg_addr == outcfg_pkg::OUT2_DIV_MID_OFS)
				restart_d = 1'b1;
			else if (reg_addr == outcfg_pkg::OUT2_DIV_LOW_OFS)
				restart_d = 1'b1;
			else if (reg_addr == outcfg_pkg::OUT2_DELAY_OFS)
				restart_d = 1'b1;
			else if (reg_addr == outcfg_pkg::OUT3_DIV_HIGH_OFS)
				restart_d = 1'b1;
			else if (reg_addr == outcfg_pkg::OUT3_DIV_MID_OFS)
				restart_d = 1'b1;
			else if (reg_addr == outcfg_pkg::OUT3_DIV_LOW_OFS)
				restart_d = 1'b1;
			else if (reg_addr == outcfg_pkg::OUT3_DELAY_OFS)
				restart_d = 1'b1;
		end
	end

	// Restart is registered so stages see the newly stored values
	always_ff @(posedge core_clk)
	begin
		if (srst)
			restart_q <= 1'b0;
		else
			restart_q <= restart_d;
	end

	// Register reads; unmapped offsets read zero
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			reg_rdata    <= 8'h00;
			reg_rd_valid <= 1'b0;
		end
		else
		begin
			reg_rd_valid <= reg_rd_en;
			if (!reg_rd_en)
				reg_rdata <= reg_rdata;
			else if (reg_addr == outcfg_pkg::OUT2_DIV_HIGH_OFS)
				reg_rdata <= out2_div_high_q;
			else if (reg_addr == outcfg_pkg::OUT2_DIV_MID_OFS)
				reg_rdata <= out2_div_mid_q;
			else if (reg_addr == outcfg_pkg::OUT2_DIV_LOW_OFS)
				reg_rdata <= out2_div_low_q;
			else if (reg_addr == outcfg_pkg::OUT2_PHASE_STR_OFS)
				reg_rdata <= out2_phase_str_q;
			else if (reg_addr == outcfg_pkg::OUT2_DELAY_OFS)
				reg_rdata <= out2_delay_q;
			else if (reg_addr == outcfg_pkg::OUT2_SUPPLY_DRV_OFS)
				reg_rdata <= out2_supply_drv_q;
			else if (reg_addr == outcfg_pkg::OUT3_DIV_HIGH_OFS)
				reg_rdata <= out3_div_high_q;
			else if (reg_addr == outcfg_pkg::OUT3_DIV_MID_OFS)
				reg_rdata <= out3_div_mid_q;
			else if (reg_addr == outcfg_pkg::OUT3_DIV_LOW_OFS)
				reg_rdata <= out3_div_low_q;
			else if (reg_addr == outcfg_pkg::OUT3_PHASE_STR_OFS)
				reg_rdata <= out3_phase_str_q;
			else if (reg_addr == outcfg_pkg::OUT3_DELAY_OFS)
				reg_rdata <= out3_delay_q;
			else if (reg_addr == outcfg_pkg::OUT3_SUPPLY_DRV_OFS)
				reg_rdata <= out3_supply_drv_q;
			else
				reg_rdata <= 8'h00;
		end
	end

	// Registered driver controls toward the analog output cells
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			out2_drv_ctrl <= '0;
			out3_drv_ctrl <= '0;
		end
		else
		begin
			out2_drv_ctrl <= drv_decode(out2_phase_str_q, out2_delay_q, out2_supply_drv_q);
			out3_drv_ctrl <= drv_decode(out3_phase_str_q, out3_delay_q, out3_supply_drv_q);
		end
	end

	assign out2_div_value = div_assemble(out2_div_high_q, out2_div_mid_q, out2_div_low_q);
	assign out3_div_value = div_assemble(out3_div_high_q, out3_div_mid_q, out3_div_low_q);

	// Output two divider, delay and pin routing
	output_stage u_out2 (
		.core_clk            (core_clk),
		.srst                (srst),
		.restart             (restart_q),
		.div_value           (out2_div_value),
		.coarse_delay        (out2_delay_q[outcfg_pkg::COARSE_DLY_MSB:0]),
		.phase_sel           (out2_phase_str_q[outcfg_pkg::PHASE_SEL_LSB +: 2]),
		.positive_pin_source (out2_positive_pin_source),
		.negative_pin_source (out2_negative_pin_source)
	);

	// Output three divider, delay and pin routing
	output_stage u_out3 (
		.core_clk            (core_clk),
		.srst                (srst),
		.restart             (restart_q),
		.div_value           (out3_div_value),
		.coarse_delay        (out3_delay_q[outcfg_pkg::COARSE_DLY_MSB:0]),
		.phase_sel           (out3_phase_str_q[outcfg_pkg::PHASE_SEL_LSB +: 2]),
		.positive_pin_source (out3_positive_pin_source),
		.negative_pin_source (out3_negative_pin_source)
	);

endmodule : output_divider_config_regs

// ---- verilog/output_stage.sv ----
`timescale 1ns/10ps
module output_stage (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        restart,
	input  wire logic [19:0] div_value,
	input  wire logic [5:0]  coarse_delay,
	input  wire logic [1:0]  phase_sel,
	output logic             positive_pin_source,
	output logic             negative_pin_source
);

	outcfg_pkg::stage_state_t state_q;
	logic [5:0]  dly_cnt_q;
	logic [19:0] div_cnt_q;
	logic        true_clock_q;
	logic [19:0] half_div;

	assign half_div = div_value >> 1;

	// Sequencer: hold off coarse delay cycles after restart, then divide
	always_ff @(posedge core_clk)
	begin
		if (srst || restart)
		begin
			state_q      <= outcfg_pkg::ST_WAIT;
			dly_cnt_q    <= 6'h00;
			div_cnt_q    <= 20'h00000;
			true_clock_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				outcfg_pkg::ST_WAIT:
				begin
					if (dly_cnt_q == coarse_delay)
						state_q <= outcfg_pkg::ST_RUN;
					else
						dly_cnt_q <= dly_cnt_q + 6'h01;
				end
				outcfg_pkg::ST_RUN:
				begin
					// Divide values below two cannot be built from whole cycles
					if (div_value < outcfg_pkg::DIV_MIN_RUN)
					begin
						div_cnt_q    <= 20'h00000;
						true_clock_q <= 1'b0;
					end
					else
					begin
						if (div_cnt_q >= div_value - 20'h00001)
							div_cnt_q <= 20'h00000;
						else
							div_cnt_q <= div_cnt_q + 20'h00001;
						true_clock_q <= (div_cnt_q < half_div);
					end
				end
				default:
					state_q <= outcfg_pkg::ST_WAIT;
			endcase
		end
	end

	// Pin routing from the phase selection
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			positive_pin_source <= 1'b0;
			negative_pin_source <= 1'b1;
		end
		else
		begin
			case (phase_sel)
				outcfg_pkg::PHASE_TRUE_COMP:
				begin
					positive_pin_source <= true_clock_q;
					negative_pin_source <= ~true_clock_q;
				end
				outcfg_pkg::PHASE_TRUE_TRUE:
				begin
					positive_pin_source <= true_clock_q;
					negative_pin_source <= true_clock_q;
				end
				outcfg_pkg::PHASE_COMP_COMP:
				begin
					positive_pin_source <= ~true_clock_q;
					negative_pin_source <= ~true_clock_q;
				end
				default:
				begin
					positive_pin_source <= ~true_clock_q;
					negative_pin_source <= true_clock_q;
				end
			endcase
		end
	end

endmodule : output_stage
